// *** design/sdmf_ckmon.sv ***
// Modulator clock synchroniser, edge finder and absence detector
`timescale 1ns/100ps
module sdmf_ckmon #(
    parameter int LIMIT = sdmf_pkg::SDMF_CKF_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic mod_clk,
    input wire logic mod_data,
    output sdmf_pkg::sdmf_smp_t smp,
    output logic clk_fail
);
    import sdmf_pkg::*;

    logic [2:0] ck_sync_r;
    logic [2:0] ck_sync_nxt;
    logic [2:0] dt_sync_r;
    logic [2:0] dt_sync_nxt;
    logic ck_lvl_r;
    logic ck_lvl_nxt;
    logic [8:0] gap_r;
    logic [8:0] gap_nxt;
    logic fail_r;
    logic fail_nxt;
    sdmf_smp_t smp_r;
    sdmf_smp_t smp_nxt;
    logic ck_edge;

    // Edge seen once second and third stages agree on a new level
    always_comb begin
        ck_sync_nxt = {ck_sync_r[1:0], mod_clk};
        dt_sync_nxt = {dt_sync_r[1:0], mod_data};
        ck_lvl_nxt = ck_lvl_r;
        ck_edge = 1'b0;
        if (ck_sync_r[1] == ck_sync_r[2] && ck_sync_r[2] != ck_lvl_r) begin
            ck_lvl_nxt = ck_sync_r[2];
            ck_edge = 1'b1;
        end
        smp_nxt.valid = ck_edge && ck_sync_r[2];   // Sample on rising edge
        smp_nxt.bit_val = dt_sync_r[2];
        // Count gap, restart at any edge
        gap_nxt = gap_r;
        fail_nxt = fail_r;
        if (ck_edge) begin
            gap_nxt = 9'h000;   // (R06)
            fail_nxt = 1'b0;
        end else if (gap_r != 9'(LIMIT)) begin
            gap_nxt = gap_r + 9'h001;   // (R06)
        end
        if (!ck_edge && gap_r == 9'(LIMIT - 1)) begin
            fail_nxt = 1'b1;   // (R03)
        end
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ck_sync_r <= 3'h0;
            dt_sync_r <= 3'h0;
            ck_lvl_r <= 1'b0;
            gap_r <= 9'h000;
            fail_r <= 1'b0;
            smp_r <= '0;
        end else begin
            ck_sync_r <= ck_sync_nxt;
            dt_sync_r <= dt_sync_nxt;
            ck_lvl_r <= ck_lvl_nxt;
            gap_r <= gap_nxt;
            fail_r <= fail_nxt;
            smp_r <= smp_nxt;
        end
    end

    assign smp = smp_r;
    assign clk_fail = fail_r;
endmodule

// *** design/sdmf_pkg.sv ***
// Package: constants and carriers of the sigma-delta monitor filter
package sdmf_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] SDMF_OFS_CTRL   = 8'h00;
    localparam logic [7:0] SDMF_OFS_HLT    = 8'h04;
    localparam logic [7:0] SDMF_OFS_LLT    = 8'h08;
    localparam logic [7:0] SDMF_OFS_ZCT    = 8'h0C;
    localparam logic [7:0] SDMF_OFS_STAT   = 8'h10;
    localparam logic [7:0] SDMF_OFS_MASK   = 8'h14;
    localparam logic [7:0] SDMF_OFS_PDATA  = 8'h18;
    localparam logic [7:0] SDMF_OFS_CDATA  = 8'h1C;

    // ==========================================================
    // Control field positions
    localparam int SDMF_CTRL_EN       = 0;
    localparam int SDMF_CTRL_CORD_LSB = 1;
    localparam int SDMF_CTRL_CORD_W   = 2;
    localparam int SDMF_CTRL_COSR_LSB = 4;
    localparam int SDMF_CTRL_COSR_W   = 5;
    localparam int SDMF_CTRL_PSH_LSB  = 9;
    localparam int SDMF_CTRL_PSH_W    = 5;

    // Status bit positions
    localparam int SDMF_ST_HIGH = 0;
    localparam int SDMF_ST_LOW  = 1;
    localparam int SDMF_ST_ZC   = 2;
    localparam int SDMF_ST_CKF  = 3;
    localparam int SDMF_ST_PRDY = 4;
    localparam int SDMF_ST_W    = 5;

    // ==========================================================
    // Reset values
    localparam logic [31:0] SDMF_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] SDMF_HLT_RST  = 16'h7FFF;
    localparam logic [15:0] SDMF_LLT_RST  = 16'h8000;
    localparam logic [15:0] SDMF_ZCT_RST  = 16'h0000;

    // ==========================================================
    // Timing: modulator clock absence limit in system clock cycles
    localparam int SDMF_CKF_CYCLES = 256;
    // Primary filter: sinc3, oversampling ratio
    localparam int SDMF_PRI_OSR    = 32;
    localparam int SDMF_ACC_W      = 32;

    // Modulator sample carrier
    typedef struct packed {
        logic valid;
        logic bit_val;
    } sdmf_smp_t;

    // Comparator threshold carrier
    typedef struct packed {
        logic signed [15:0] high;
        logic signed [15:0] low;
        logic signed [15:0] zero;
    } sdmf_thr_t;

endpackage

// *** design/sdmf_sinc.sv ***
// Sinc filter of selectable order and decimation ratio
`timescale 1ns/100ps
module sdmf_sinc #(
    parameter int ACC_W = 32
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic enable,
    input wire sdmf_pkg::sdmf_smp_t smp,
    input wire logic [1:0] order,
    input wire logic [8:0] osr_m1,
    output logic [ACC_W-1:0] result,
    output logic result_vld
);
    import sdmf_pkg::*;

    logic [ACC_W-1:0] integ_r [3];
    logic [ACC_W-1:0] integ_nxt [3];
    logic [ACC_W-1:0] comb_r [3];
    logic [ACC_W-1:0] comb_nxt [3];
    logic [ACC_W-1:0] dly_r [3];
    logic [ACC_W-1:0] dly_nxt [3];
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;
    logic [ACC_W-1:0] result_r;
    logic [ACC_W-1:0] result_nxt;
    logic vld_r;
    logic vld_nxt;
    logic [ACC_W-1:0] din;
    logic [ACC_W-1:0] cin;

    // Integrators at sample rate, combs at decimated rate
    always_comb begin
        din = {{(ACC_W-1){1'b0}}, smp.bit_val};
        cin = '0;
        cnt_nxt = cnt_r;
        result_nxt = result_r;
        vld_nxt = 1'b0;
        for (int i = 0; i < 3; i++) begin
            integ_nxt[i] = integ_r[i];
            comb_nxt[i] = comb_r[i];
            dly_nxt[i] = dly_r[i];
        end
        if (enable && smp.valid) begin
            integ_nxt[0] = integ_r[0] + din;
            integ_nxt[1] = integ_r[1] + integ_r[0];
            integ_nxt[2] = integ_r[2] + integ_r[1];
            if (cnt_r == osr_m1) begin
                cnt_nxt = '0;
                cin = integ_r[(order > 2'h2) ? 2'h2 : order];   // Code 3 runs as sinc3
                for (int i = 0; i < 3; i++) begin
                    if (i <= int'(order)) begin
                        comb_nxt[i] = cin - dly_r[i];
                        dly_nxt[i] = cin;
                        cin = comb_nxt[i];
                    end
                end
                result_nxt = cin;
                vld_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 9'h001;
            end
        end
        if (!enable) begin
            for (int i = 0; i < 3; i++) begin
                integ_nxt[i] = '0;
                comb_nxt[i] = '0;
                dly_nxt[i] = '0;
            end
            cnt_nxt = '0;
        end
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < 3; i++) begin
                integ_r[i] <= '0;
                comb_r[i] <= '0;
                dly_r[i] <= '0;
            end
            cnt_r <= 9'h000;
            result_r <= '0;
            vld_r <= 1'b0;
        end else begin
            integ_r <= integ_nxt;
            comb_r <= comb_nxt;
            dly_r <= dly_nxt;
            cnt_r <= cnt_nxt;
            result_r <= result_nxt;
            vld_r <= vld_nxt;
        end
    end

    assign result = result_r;
    assign result_vld = vld_r;
endmodule

// *** design/sdmf_top.sv ***
// Top of the sigma-delta monitor filter: registers, filters, comparator
`timescale 1ns/100ps

// Operation
// (R01) Comparator sinc filter result is checked against high, low and zero thresholds.
// (R02) Result above high or below low raises the comparator interrupt.
// (R03) Modulator clock absent 256 system cycles declares failure and interrupts.
// (R04) High limit at minimum and low at maximum always asserts interrupt.
// (R05) Primary decimation filter gives a deterministic result for a known bitstream.
// (R06) Absence counter restarts on every observed modulator clock edge.
module sdmf_top #(
    parameter int ACC_W = sdmf_pkg::SDMF_ACC_W,
    parameter int PRI_OSR = sdmf_pkg::SDMF_PRI_OSR
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic mod_clk,
    input wire logic mod_data,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);
    import sdmf_pkg::*;

    // ==========================================================
    // Declarations
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    sdmf_thr_t thr_r;
    sdmf_thr_t thr_nxt;
    logic [SDMF_ST_W-1:0] stat_r;
    logic [SDMF_ST_W-1:0] stat_nxt;
    logic [SDMF_ST_W-1:0] mask_r;
    logic [SDMF_ST_W-1:0] mask_nxt;
    logic [31:0] pdata_r;
    logic [31:0] pdata_nxt;
    logic signed [15:0] cdata_r;
    logic signed [15:0] cdata_nxt;
    logic above_r;
    logic above_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [SDMF_ST_W-1:0] ev;
    sdmf_smp_t smp;
    logic clk_fail;
    logic clk_fail_d_r;
    logic clk_fail_d_nxt;
    logic [ACC_W-1:0] pri_res;
    logic pri_vld;
    logic [ACC_W-1:0] cmp_res;
    logic cmp_vld;
    logic signed [15:0] cmp_val;
    logic enable;
    logic hi_hit;
    logic lo_hit;
    logic zc_hit;
    logic now_above;

    assign enable = ctrl_r[SDMF_CTRL_EN];

    // ==========================================================
    // Pin front end and clock-fail detector
    sdmf_ckmon #(
        .LIMIT(SDMF_CKF_CYCLES)
    ) u_ckmon (
        .sys_clk(sys_clk),
        .srst(srst),
        .mod_clk(mod_clk),
        .mod_data(mod_data),
        .smp(smp),
        .clk_fail(clk_fail)
    );

    // ==========================================================
    // Primary filter: fixed sinc3, fixed ratio, deterministic output
    sdmf_sinc #(
        .ACC_W(ACC_W)
    ) u_pri (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(enable),
        .smp(smp),
        .order(2'h2),
        .osr_m1(9'(PRI_OSR - 1)),
        .result(pri_res),
        .result_vld(pri_vld)
    );   // (R05)

    // Comparator filter: order and ratio from the control register
    sdmf_sinc #(
        .ACC_W(ACC_W)
    ) u_cmp (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(enable),
        .smp(smp),
        .order(ctrl_r[SDMF_CTRL_CORD_LSB +: SDMF_CTRL_CORD_W]),
        .osr_m1({4'h0, ctrl_r[SDMF_CTRL_COSR_LSB +: SDMF_CTRL_COSR_W]}),
        .result(cmp_res),
        .result_vld(cmp_vld)
    );   // (R01)

    // ==========================================================
    // Comparator: low 16 bits of the result against thresholds, signed compare
    always_comb begin
        cmp_val = cmp_res[15:0];
        hi_hit = 1'b0;
        lo_hit = 1'b0;
        zc_hit = 1'b0;
        now_above = above_r;
        cdata_nxt = cdata_r;
        above_nxt = above_r;
        if (cmp_vld) begin
            cdata_nxt = cmp_val;
            hi_hit = cmp_val > thr_r.high;   // (R01) (R02) (R04)
            lo_hit = cmp_val < thr_r.low;    // (R01) (R02) (R04)
            now_above = cmp_val >= thr_r.zero;
            zc_hit = now_above != above_r;   // (R01)
            above_nxt = now_above;
        end
    end

    // Primary result holding register; scaled by a right shift
    always_comb begin
        pdata_nxt = pdata_r;
        if (pri_vld) begin
            pdata_nxt = 32'(pri_res >> ctrl_r[SDMF_CTRL_PSH_LSB +: SDMF_CTRL_PSH_W]);   // (R05)
        end
    end

    // ==========================================================
    // Events into sticky status; set beats write-one-to-clear
    always_comb begin
        ev = '0;
        ev[SDMF_ST_HIGH] = hi_hit;   // (R02)
        ev[SDMF_ST_LOW] = lo_hit;    // (R02)
        ev[SDMF_ST_ZC] = zc_hit;
        ev[SDMF_ST_CKF] = clk_fail && !clk_fail_d_r;   // (R03)
        ev[SDMF_ST_PRDY] = pri_vld;
        stat_nxt = stat_r;
        if (wr && addr == SDMF_OFS_STAT) begin
            stat_nxt = stat_r & ~wdata[SDMF_ST_W-1:0];
        end
        stat_nxt = stat_nxt | ev;
        clk_fail_d_nxt = clk_fail;
        irq_nxt = |(stat_nxt & mask_r);   // (R02) (R03)
    end

    // ==========================================================
    // Register writes
    always_comb begin
        ctrl_nxt = ctrl_r;
        thr_nxt = thr_r;
        mask_nxt = mask_r;
        if (wr) begin
            unique case (addr)
                SDMF_OFS_CTRL: ctrl_nxt = wdata;
                SDMF_OFS_HLT: thr_nxt.high = wdata[15:0];
                SDMF_OFS_LLT: thr_nxt.low = wdata[15:0];
                SDMF_OFS_ZCT: thr_nxt.zero = wdata[15:0];
                SDMF_OFS_MASK: mask_nxt = wdata[SDMF_ST_W-1:0];
                default: ;
            endcase
        end
    end

    // Register reads; data stand in the cycle after the strobe only
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (rd) begin
            unique case (addr)
                SDMF_OFS_CTRL: rdata_nxt = ctrl_r;
                SDMF_OFS_HLT: rdata_nxt = {16'h0000, thr_r.high};
                SDMF_OFS_LLT: rdata_nxt = {16'h0000, thr_r.low};
                SDMF_OFS_ZCT: rdata_nxt = {16'h0000, thr_r.zero};
                SDMF_OFS_STAT: rdata_nxt = {27'h0, stat_r};
                SDMF_OFS_MASK: rdata_nxt = {27'h0, mask_r};
                SDMF_OFS_PDATA: rdata_nxt = pdata_r;
                SDMF_OFS_CDATA: rdata_nxt = {{16{cdata_r[15]}}, cdata_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Settings registers: control, thresholds and mask
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_r <= SDMF_CTRL_RST;
            thr_r.high <= SDMF_HLT_RST;
            thr_r.low <= SDMF_LLT_RST;
            thr_r.zero <= SDMF_ZCT_RST;
            mask_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            thr_r <= thr_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Comparator result and the side of the zero level it was on
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cdata_r <= 16'h0000;
            above_r <= 1'b0;
        end else begin
            cdata_r <= cdata_nxt;
            above_r <= above_nxt;
        end
    end

    // Primary result holding register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pdata_r <= 32'h0000_0000;
        end else begin
            pdata_r <= pdata_nxt;
        end
    end

    // Sticky status, interrupt line and clock-fail onset delay
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stat_r <= '0;
            irq_r <= 1'b0;
            clk_fail_d_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r <= irq_nxt;
            clk_fail_d_r <= clk_fail_d_nxt;
        end
    end

    // Read data register; falls back to zero one cycle after a read
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;
    assign irq = irq_r;
endmodule

// *** dv/sdmf_mod_model.sv ***
// Behavioural sigma-delta modulator driving clock and bitstream
`timescale 1ns/100ps
module sdmf_mod_model (
    input wire logic run,
    input wire logic level,
    output logic mod_clk,
    output logic mod_data
);
    // Clock toggles only while running and stands still otherwise;
    // a small phase offset keeps its edges off the system clock edges
    initial begin
        mod_clk = 1'b0;
        mod_data = 1'b0;
        #0.3;
        forever begin
            #62.5;
            if (run) begin
                mod_clk = ~mod_clk;
            end
        end
    end
    // New bit after each falling edge, away from the sampling edge
    always @(negedge mod_clk) begin
        mod_data <= level;
    end
endmodule

// *** dv/sdmf_monitor.sv ***
// Port checker of the sigma-delta monitor filter
`timescale 1ns/100ps
module sdmf_monitor #(
    parameter int ACC_W = 32,
    parameter int PRI_OSR = 32
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic mod_clk,
    input wire logic mod_data,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic irq
);
    import sdmf_pkg::*;
    logic [4:0] mask_r;
    logic [15:0] hlt_r;
    logic [15:0] llt_r;
    logic en_r;
    logic mclk_q;
    logic [9:0] quiet_r;
    logic [9:0] st_r;
    logic self_test;

    // =========================================================
    // Shadow of written settings and modulator clock quiet time
    assign self_test = hlt_r == 16'h8000 && llt_r == 16'h7FFF && mask_r[1:0] != 2'h0
        && en_r && quiet_r < 10'h064;
    always_ff @(posedge sys_clk) begin
        mclk_q <= mod_clk;
        if (srst) begin
            mask_r <= 5'h00;
            hlt_r <= SDMF_HLT_RST;
            llt_r <= SDMF_LLT_RST;
            en_r <= 1'b0;
            quiet_r <= 10'h000;
            st_r <= 10'h000;
        end
        else begin
            if (wr && addr == SDMF_OFS_MASK) mask_r <= wdata[4:0];
            if (wr && addr == SDMF_OFS_HLT) hlt_r <= wdata[15:0];
            if (wr && addr == SDMF_OFS_LLT) llt_r <= wdata[15:0];
            if (wr && addr == SDMF_OFS_CTRL) en_r <= wdata[0];
            // Restart on any pin edge, saturate otherwise
            quiet_r <= (mod_clk != mclk_q) ? 10'h000 : quiet_r + 10'(quiet_r != 10'h3FF);
            st_r <= self_test ? st_r + 10'(st_r != 10'h3FF) : 10'h000;
        end
    end

    // =========================================================
    // Assertions
    default clocking mon_cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    read_idle_a: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero without a read");
    irq_after_reset_a: assert property ($fell(srst) |-> !irq)
        else $error("interrupt high right after reset");
    high_readback_a: assert property (rd && addr == SDMF_OFS_HLT |=> rdata[15:0] == $past(hlt_r))
        else $error("high limit read back wrong");
    mask_gate_a: assert property (mask_r == 5'h00 && $past(mask_r) == 5'h00 |-> !irq)
        else $error("interrupt with all sources masked");
    clk_fail_irq_a: assert property (quiet_r == 10'h10E && mask_r[3] |-> irq)
        else $error("no interrupt after modulator clock loss");
    clk_fail_early_a: assert property ($rose(irq) && $past(mask_r, 2) == 5'h08 |-> quiet_r >= 10'h100)
        else $error("clock failure flagged too early");
    self_test_irq_a: assert property (st_r == 10'h3E8 |-> irq)
        else $error("self test limits gave no interrupt");
    self_test_c: cover property (st_r == 10'h3E8 && irq);
    clk_fail_c: cover property ($rose(irq) && mask_r == 5'h08);
    high_read_c: cover property (rd && addr == SDMF_OFS_HLT);
endmodule

bind sdmf_top sdmf_monitor #(.ACC_W(ACC_W), .PRI_OSR(PRI_OSR)) mon_u (
    .sys_clk(sys_clk), .srst(srst), .mod_clk(mod_clk), .mod_data(mod_data), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

// *** dv/testbench.sv ***
// Self-checking bench of the sigma-delta monitor filter
`timescale 1ns/100ps
module testbench;
    import sdmf_pkg::*;
    logic sys_clk = 1'b0;
    logic srst, mod_clk, mod_data, wr, rd, irq, run, level;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    int num_errors = 0;
    int total_checks = 0;

    // =========================================================
    // Clock, design and modulator
    always #2 sys_clk = ~sys_clk;
    sdmf_top dut_u (.sys_clk(sys_clk), .srst(srst), .mod_clk(mod_clk), .mod_data(mod_data),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    sdmf_mod_model model_u (.run(run), .level(level), .mod_clk(mod_clk), .mod_data(mod_data));

    // =========================================================
    // Bus, compare and closing tasks
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk(name, exp, rdata & m);
    endtask
    task automatic chk_irq(input logic exp);
        total_checks++;
        if (irq !== exp) begin
            num_errors++;
            $display("wrong value irq expected %b seen %b", exp, irq);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end
        else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // =========================================================
    // Watchdog
    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        wrap_up();
    end

    // =========================================================
    // Test sequence
    initial begin
        srst <= 1'b1;
        addr <= 8'h00;
        wdata <= 32'h0;
        wr <= 1'b0;
        rd <= 1'b0;
        run <= 1'b1;
        level <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        // Reset values and an unmapped place
        chk_reg("ctrl", SDMF_OFS_CTRL, 32'hFFFFFFFF, SDMF_CTRL_RST);
        chk_reg("high", SDMF_OFS_HLT, 32'h0000FFFF, {16'h0, SDMF_HLT_RST});
        chk_reg("low", SDMF_OFS_LLT, 32'h0000FFFF, {16'h0, SDMF_LLT_RST});
        chk_reg("zero", SDMF_OFS_ZCT, 32'h0000FFFF, 32'h0);
        chk_reg("stat", SDMF_OFS_STAT, 32'hFFFFFFFF, 32'h0);
        chk_reg("mask", SDMF_OFS_MASK, 32'hFFFFFFFF, 32'h0);
        chk_reg("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
        // All-ones stream: sinc3 of ratio 32 settles at 32768, shifted by 4
        wr_reg(SDMF_OFS_CTRL, 32'h00000835);
        wait_cyc(5000);
        chk_reg("pdata", SDMF_OFS_PDATA, 32'hFFFFFFFF, 32'h00000800);
        chk_reg("ready", SDMF_OFS_STAT, 32'h00000010, 32'h00000010);
        // Each comparator order at ratio 4 settles at 4 to the order
        for (int k = 0; k < 3; k++) begin
            wr_reg(SDMF_OFS_CTRL, 32'h00000831 | (k << 1));
            wait_cyc(1000);
            chk_reg("cdata", SDMF_OFS_CDATA, 32'hFFFFFFFF, 32'h4 << (2 * k));
        end
        // Extreme limits force the interrupt
        wr_reg(SDMF_OFS_MASK, 32'h3);
        wr_reg(SDMF_OFS_HLT, 32'h00008000);
        wr_reg(SDMF_OFS_LLT, 32'h00007FFF);
        wait_cyc(1100);
        chk_irq(1'b1);
        chk_reg("self", SDMF_OFS_STAT, 32'h3, 32'h3);
        // Value 64 inside 100 and -100, then above 50, then below 100
        wr_reg(SDMF_OFS_HLT, 32'h00000064);
        wr_reg(SDMF_OFS_LLT, 32'h0000FF9C);
        wr_reg(SDMF_OFS_STAT, 32'h1F);
        wait_cyc(600);
        chk_reg("inside", SDMF_OFS_STAT, 32'h3, 32'h0);
        chk_irq(1'b0);
        wr_reg(SDMF_OFS_HLT, 32'h00000032);
        wait_cyc(600);
        chk_reg("above", SDMF_OFS_STAT, 32'h3, 32'h1);
        chk_irq(1'b1);
        wr_reg(SDMF_OFS_HLT, 32'h00007FFF);
        wr_reg(SDMF_OFS_LLT, 32'h00000064);
        wr_reg(SDMF_OFS_STAT, 32'h1F);
        wait_cyc(600);
        chk_reg("below", SDMF_OFS_STAT, 32'h3, 32'h2);
        // Stream drop across a zero level of 32
        wr_reg(SDMF_OFS_ZCT, 32'h00000020);
        wr_reg(SDMF_OFS_STAT, 32'h1F);
        level <= 1'b0;
        wait_cyc(1000);
        chk_reg("cross", SDMF_OFS_STAT, 32'h4, 32'h4);
        level <= 1'b1;
        // A short gap and the first 200 cycles of a second stay silent; the second, held on, is a failure
        wr_reg(SDMF_OFS_STAT, 32'h1F);
        wr_reg(SDMF_OFS_MASK, 32'h8);
        run <= 1'b0;
        wait_cyc(200);
        run <= 1'b1;
        wait_cyc(40);
        run <= 1'b0;
        wait_cyc(200);
        chk_reg("gap", SDMF_OFS_STAT, 32'h8, 32'h0);
        chk_irq(1'b0);
        wait_cyc(300);
        chk_reg("lost", SDMF_OFS_STAT, 32'h8, 32'h8);
        chk_irq(1'b1);
        run <= 1'b1;
        wait_cyc(40);
        wr_reg(SDMF_OFS_STAT, 32'h8);
        wait_cyc(4);
        chk_irq(1'b0);
        wrap_up();
    end
endmodule
